// file: rtl/pgm_monitor.sv
// supply valid pin logic, rail fault latches and warning interrupts
//
// How it works
// - one select bit per rail; in dual phase only master switcher selectable.
// - a rail that is switched off never counts as bad.
// - config bit adds thermal warning as a supply valid source.
// - valid only if selected rails, warning, overvoltage and shutdown flags good.
// - window bit 0 checks under only; 1 checks under and over.
// - software picks pin polarity and push-pull or open-drain drive.
// - mode bit, loaded at config, 0 gated, 1 continuous.
// - gated mode starts asserted after config loading.
// - gated mode freezes the pin 800 us after enable or voltage change.
// - each rail fault in run state sets its latch; in gated mode monitoring resumes only after clearing.
// - write one clears overvoltage, shutdown and rail fault bits.
// - continuous mode asserts after loading, drops at any rail enable.
// - continuous mode follows regulation status at once, each cycle without a new rail enable.
// - fault latches hold until software writes one to that bit.
// - pin held inactive while a rail ramps between targets.
// - in continuous mode valid returns when bad rails recover, unless fault gating set.
// - fault gating bit holds pin inactive while any fault latch pends.
// - switcher 20 us in peak limit sets its flag and drives irq low.
// - linear 20 us in current limit sets its flag and drives irq low.
// - live limit status readable, flag cleared by one, mask suppresses irq.
// - thermal warning sets flag, irq low, live status, write-one clear, mask.
// - status bit reads 1 when valid; polarity affects the pin only.
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "pgm_defines.svh"
module pgm_monitor
   import pgm_pkg::*;
#(
   parameter int unsigned GATE_CYC = `PGM_GATE_CYC
) (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic otp_done_in,
   input wire logic otp_mode_in,
   input wire logic [3:0] change_req_in,
   input wire pgm_sense_type sense_in,
   input wire logic [7:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rdata_out,
   output logic supply_valid_out,
   output logic supply_valid_oe_out,
   output logic irq_n_out
);
   // ==========================================
   // input synchronisation
   pgm_sense_type sense;
   logic otp_done;
   logic otp_mode;
   pgm_sync #(.W($bits(pgm_sense_type) + 2)) u_sync (
      .clock_in(clock_in),
      .rstn_in(rstn_in),
      .async_in({sense_in, otp_done_in, otp_mode_in}),
      .sync_out({sense, otp_done, otp_mode})
   );

   // ==========================================
   // registers
   logic [9:0] ctrl1_ff;
   logic [3:0] ctrl2_ff;
   logic [3:0] fault_ff;
   logic [6:0] flags_ff;
   logic [6:0] mask_ff;
   logic config_ff;
   logic [15:0] rdata_ff;
   logic mode_loaded_ff;
   logic [3:0] rail_on_ff;
   logic [3:0] change_ff;
   pgm_state_type state_ff;
   pgm_state_type nxt_state;
   logic [$clog2(GATE_CYC + 1)-1:0] gate_cnt_ff;
   logic valid_ff;
   logic nxt_valid;
   pgm_pin_type pin_ff;

   function automatic logic hit(input logic [7:0] a);
      hit = wr_in && (addr_in == a);
   endfunction

   // ==========================================
   // rail evaluation
   wire logic [3:0] sel_mask = {2'b11, ~ctrl2_ff[`PGM_C2_DUAL_BIT], 1'b1};
   wire logic [1:0] sel_linear_monitor = ctrl1_ff[`PGM_C1_SEL_LSB+3 -: 2];
   wire logic [1:0] sel_switcher_monitor = ctrl1_ff[`PGM_C1_SEL_LSB+1 -: 2];
   wire logic [3:0] rail_sel = {sel_linear_monitor[1:0], sel_switcher_monitor} & sel_mask;
   wire logic [3:0] monitor_window_sel = ctrl1_ff[`PGM_C1_WIN_LSB +: 4];
   wire logic [3:0] rail_ok = sense.under_ok & (sense.over_ok | ~monitor_window_sel);
   wire logic [3:0] rail_watched = rail_sel & sense.rail_on;
   wire logic [3:0] rail_bad = rail_watched & ~rail_ok;
   wire logic ramping = |(rail_watched & sense.ramping);
   wire logic sel_thermal_warn_monitor = ctrl2_ff[`PGM_C2_TWARN_BIT];
   wire logic thermal_warn_live = sense.thermal_warn;
   wire logic overvoltage_irq_flag = flags_ff[`PGM_IRQ_OVP_BIT];
   wire logic thermal_shutdown_irq_flag = flags_ff[`PGM_IRQ_TSD_BIT];
   wire logic fault_holds_valid_low = ctrl2_ff[`PGM_C2_FGATE_BIT];
   wire logic sources_ok = ~|rail_bad && !(sel_thermal_warn_monitor && thermal_warn_live) &&
      !overvoltage_irq_flag && !thermal_shutdown_irq_flag;
   wire logic fault_block = fault_holds_valid_low && |fault_ff;
   wire logic level_now = sources_ok && !ramping && !fault_block;
   wire logic valid_pin_mode_sel = mode_loaded_ff;
   wire logic new_enable = |(sense.rail_on & ~rail_on_ff);
   wire logic restart = new_enable || |(change_req_in & ~change_ff);
   wire logic gate_done = (gate_cnt_ff == '0);

   // ==========================================
   // supply valid state machine
   always_comb begin
      nxt_state = state_ff;
      nxt_valid = valid_ff;
      case (state_ff)
         pgm_st_load: begin
            nxt_valid = 1'b1;
            if (otp_done) begin
               nxt_state = pgm_st_run;
            end
         end
         pgm_st_gate: begin
            // output frozen while gating runs
            if (gate_done && !restart) begin
               nxt_state = pgm_st_run;
            end
         end
         default: begin
            if (!valid_pin_mode_sel) begin
               if (restart) begin
                  nxt_state = pgm_st_gate;
               end else begin
                  // in gated mode a drop also needs the fault latch cleared to recover
                  nxt_valid = level_now && !(|fault_ff && !valid_ff);
               end
            end else if (new_enable) begin
               nxt_valid = 1'b0;
            end else begin
               nxt_valid = level_now;
            end
         end
      endcase
   end

   // ==========================================
   // control registers and state
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         ctrl1_ff <= `PGM_RST_CTRL1;
         ctrl2_ff <= `PGM_RST_CTRL2;
         mask_ff <= `PGM_RST_MASK;
         config_ff <= 1'b0;
         mode_loaded_ff <= 1'b0;
         state_ff <= pgm_st_load;
         valid_ff <= 1'b1;
         rail_on_ff <= 4'h0;
         change_ff <= 4'h0;
      end else begin
         if (hit(`PGM_ADDR_VALID_CTRL1)) begin
            ctrl1_ff <= wdata_in[9:0];
         end
         if (hit(`PGM_ADDR_VALID_CTRL2)) begin
            ctrl2_ff <= wdata_in[3:0];
         end
         if (hit(`PGM_ADDR_IRQ_MASK)) begin
            mask_ff <= wdata_in[6:0];
         end
         if (hit(`PGM_ADDR_CONFIG)) begin
            config_ff <= wdata_in[0];
         end
         if (state_ff == pgm_st_load) begin
            mode_loaded_ff <= otp_mode;
         end else if (hit(`PGM_ADDR_VALID_CTRL2)) begin
            mode_loaded_ff <= wdata_in[`PGM_C2_MODE_BIT];
         end
         state_ff <= nxt_state;
         valid_ff <= nxt_valid;
         rail_on_ff <= sense.rail_on;
         change_ff <= change_req_in;
      end
   end

   // gating counter reloads on each enable or change request
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         gate_cnt_ff <= '0;
      end else if (restart) begin
         gate_cnt_ff <= ($bits(gate_cnt_ff))'(GATE_CYC - 1);
      end else if (!gate_done) begin
         gate_cnt_ff <= gate_cnt_ff - 1'b1;
      end
   end

   // ==========================================
   // fault latches and interrupt flags; a set beats a clear in the same cycle
   logic [3:0] limit_held;
   logic warn_held;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lim
         pgm_persist #(.COUNT(`PGM_LIMIT_CYC)) u_lim (
            .clock_in(clock_in),
            .rstn_in(rstn_in),
            .level_in(sense.in_limit[gi]),
            .held_out(limit_held[gi])
         );
      end
   endgenerate
   pgm_persist #(.COUNT(`PGM_LIMIT_CYC)) u_warn (
      .clock_in(clock_in),
      .rstn_in(rstn_in),
      .level_in(sense.thermal_warn),
      .held_out(warn_held)
   );

   wire logic [3:0] fault_clr = hit(`PGM_ADDR_FAULT) ? wdata_in[3:0] : 4'h0;
   wire logic [6:0] flag_clr = hit(`PGM_ADDR_IRQ_FLAGS) ? wdata_in[6:0] : 7'h00;
   wire logic [6:0] flag_set = {sense.thermal_sd, sense.overvoltage, warn_held, limit_held};
   wire logic rail_fault_evt = state_ff == pgm_st_run;

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         fault_ff <= 4'h0;
         flags_ff <= 7'h00;
      end else begin
         fault_ff <= (fault_ff & ~fault_clr) | (rail_fault_evt ? rail_bad : 4'h0);
         flags_ff <= (flags_ff & ~flag_clr) | flag_set;
      end
   end

   wire logic [6:0] irq_pend = flags_ff & ~mask_ff;

   // ==========================================
   // pin drive and read port
   wire logic [3:0] limit_live = sense.in_limit;
   wire logic supply_valid_live = valid_ff;
   wire logic valid_pin_polarity = ctrl1_ff[`PGM_C1_POL_BIT];
   wire logic valid_pin_open_drain = ctrl1_ff[`PGM_C1_OD_BIT];
   wire logic pin_level = valid_ff ^ ~valid_pin_polarity;
   wire logic [15:0] rd_mux =
      (addr_in == `PGM_ADDR_VALID_CTRL1) ? {6'h00, ctrl1_ff} :
      (addr_in == `PGM_ADDR_VALID_CTRL2) ? {12'h000, ctrl2_ff[3:2], mode_loaded_ff, ctrl2_ff[0]} :
      (addr_in == `PGM_ADDR_FAULT) ? {12'h000, fault_ff} :
      (addr_in == `PGM_ADDR_IRQ_FLAGS) ? {9'h000, flags_ff} :
      (addr_in == `PGM_ADDR_IRQ_MASK) ? {9'h000, mask_ff} :
      (addr_in == `PGM_ADDR_STATUS) ? {10'h000, supply_valid_live, thermal_warn_live, limit_live} :
      (addr_in == `PGM_ADDR_CONFIG) ? {15'h0000, config_ff} : 16'h0000;

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         rdata_ff <= 16'h0000;
         pin_ff <= '{level: 1'b0, oe: 1'b1};
      end else begin
         rdata_ff <= rd_in ? rd_mux : 16'h0000;
         pin_ff.level <= valid_pin_open_drain ? 1'b0 : pin_level;
         pin_ff.oe <= !valid_pin_open_drain || !pin_level;
      end
   end

   assign rdata_out = rdata_ff;
   assign supply_valid_out = pin_ff.level;
   assign supply_valid_oe_out = pin_ff.oe;
   assign irq_n_out = ~|irq_pend;
endmodule // pgm_monitor
`default_nettype wire

// file: rtl/pgm_defines.svh
// constants of the power-good and fault monitor
`ifndef PGM_DEFINES_SVH
`define PGM_DEFINES_SVH
// ==========================================
// register offsets (plain register port, 8-bit address)
`define PGM_ADDR_VALID_CTRL1 8'h00
`define PGM_ADDR_VALID_CTRL2 8'h01
`define PGM_ADDR_FAULT 8'h02
`define PGM_ADDR_IRQ_FLAGS 8'h03
`define PGM_ADDR_IRQ_MASK 8'h04
`define PGM_ADDR_STATUS 8'h05
`define PGM_ADDR_CONFIG 8'h06
// ==========================================
// field positions
// ctrl1: [3:0] select (sw0,sw1,lin0,lin1), [7:4] window, [8] polarity, [9] open drain
`define PGM_C1_SEL_LSB 0
`define PGM_C1_WIN_LSB 4
`define PGM_C1_POL_BIT 8
`define PGM_C1_OD_BIT 9
// ctrl2: [0] thermal warn select, [1] mode, [2] fault holds valid low, [3] dual phase
`define PGM_C2_TWARN_BIT 0
`define PGM_C2_MODE_BIT 1
`define PGM_C2_FGATE_BIT 2
`define PGM_C2_DUAL_BIT 3
// irq flags / mask: [3:0] current limit (sw0,sw1,lin0,lin1), [4] thermal warn, [5] ovp, [6] tsd
`define PGM_IRQ_TWARN_BIT 4
`define PGM_IRQ_OVP_BIT 5
`define PGM_IRQ_TSD_BIT 6
// status: [3:0] limit live, [4] thermal warn live, [5] supply valid live
`define PGM_ST_TWARN_BIT 4
`define PGM_ST_VALID_BIT 5
// ==========================================
// reset values
`define PGM_RST_CTRL1 10'h00F
`define PGM_RST_CTRL2 4'h0
`define PGM_RST_MASK 7'h00
// ==========================================
// timing
`define PGM_CLK_HZ 50000000
`define PGM_GATE_US 800
`define PGM_GATE_CYC ((`PGM_GATE_US * `PGM_CLK_HZ) / 1000000)
`define PGM_LIMIT_US 20
`define PGM_LIMIT_CYC ((`PGM_LIMIT_US * `PGM_CLK_HZ) / 1000000)
`endif

// file: rtl/pgm_pkg.sv
// types of the power-good and fault monitor
package pgm_pkg;
   typedef enum logic [1:0] {
      pgm_st_load,
      pgm_st_gate,
      pgm_st_run
   } pgm_state_type;
   // raw analog-side inputs per rail: sw0, sw1, lin0, lin1
   typedef struct packed {
      logic [3:0] rail_on;
      logic [3:0] under_ok;
      logic [3:0] over_ok;
      logic [3:0] ramping;
      logic [3:0] in_limit;
      logic thermal_warn;
      logic thermal_sd;
      logic overvoltage;
   } pgm_sense_type;
   // pin drive of the supply valid output
   typedef struct packed {
      logic level;
      logic oe;
   } pgm_pin_type;
endpackage

// file: rtl/pgm_sync.sv
// two-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module pgm_sync #(
   parameter int W = 1
) (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end
   assign sync_out = sync_ff;
endmodule // pgm_sync
`default_nettype wire

// file: rtl/pgm_persist.sv
// persistence timer: flags when a level has held for a set count of cycles
`timescale 1ns/1ns
`default_nettype none
module pgm_persist #(
   parameter int unsigned COUNT = 1
) (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic level_in,
   output logic held_out
);
   localparam int CW = $clog2(COUNT + 1);
   localparam logic [CW-1:0] LAST = CW'(COUNT - 1);
   logic [CW-1:0] cnt_ff;
   logic held_ff;
   wire logic done = (cnt_ff == LAST);
   always_ff @(posedge clock_in) begin
      if (!rstn_in || !level_in) begin
         cnt_ff <= '0;
         held_ff <= 1'b0;
      end else begin
         if (!done) begin
            cnt_ff <= cnt_ff + 1'b1;
         end
         held_ff <= done;
      end
   end
   assign held_out = held_ff;
endmodule // pgm_persist
`default_nettype wire

// file: bench/pgm_host_model.sv
// host side model of the supply valid wire and the interrupt line
`timescale 1ns/1ns
`default_nettype none
module pgm_host_model (
   input wire logic level_in,
   input wire logic oe_in,
   input wire logic irq_n_in,
   output logic pin_out,
   output logic irq_n_out
);
   // ==========================================
   // wire resolution
   // board pull-up: a released open-drain pin reads high, never a stale level
   assign pin_out = oe_in ? level_in : 1'b1;
   assign irq_n_out = irq_n_in;
endmodule // pgm_host_model
`default_nettype wire

// file: bench/pgm_monitor_monitor.sv
// assertion checker of the supply valid pin and warning interrupts
`timescale 1ns/1ns
`default_nettype none
module pgm_monitor_monitor
   import pgm_pkg::*;
(
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire pgm_sense_type sense_in,
   input wire logic [7:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [15:0] rdata_out,
   input wire logic supply_valid_out,
   input wire logic supply_valid_oe_out,
   input wire logic irq_n_out
);
   // ==========================================
   // shadow of pin setup, mask and persistence counts
   logic pol_ff;
   logic od_ff;
   logic [6:0] mask_ff;
   logic [10:0] lim_cnt_ff;
   logic [10:0] warn_cnt_ff;
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         pol_ff <= 1'b0;
         od_ff <= 1'b0;
         mask_ff <= 7'h00;
         lim_cnt_ff <= 11'h000;
         warn_cnt_ff <= 11'h000;
      end else begin
         if (wr_in && addr_in == 8'h00) begin
            pol_ff <= wdata_in[8];
            od_ff <= wdata_in[9];
         end
         if (wr_in && addr_in == 8'h04) begin
            mask_ff <= wdata_in[6:0];
         end
         // counts saturate so a long stay keeps the check alive
         lim_cnt_ff <= !sense_in.in_limit[0] ? 11'h000 : (lim_cnt_ff == 11'h3F2 ? lim_cnt_ff : lim_cnt_ff + 11'h001);
         warn_cnt_ff <= !sense_in.thermal_warn ? 11'h000 : (warn_cnt_ff == 11'h3F2 ? warn_cnt_ff : warn_cnt_ff + 11'h001);
      end
   end
   // ==========================================
   // properties
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rstn_in);
   sequence s_status_read;
      rd_in && addr_in == 8'h05 && !od_ff && $stable(supply_valid_out) && $stable(pol_ff);
   endsequence
   property p_rdata_idle;
      !rd_in || addr_in > 8'h06 |=> rdata_out == 16'h0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
   property p_mask_read;
      rd_in && addr_in == 8'h04 |=> rdata_out == {9'h000, mask_ff};
   endproperty
   a_mask_read: assert property (p_mask_read) else $error("mask read back wrong");
   property p_all_masked;
      mask_ff == 7'h7F |-> irq_n_out;
   endproperty
   a_all_masked: assert property (p_all_masked) else $error("irq low with all masked");
   property p_od_drive;
      od_ff && $past(od_ff) |-> !(supply_valid_oe_out && supply_valid_out);
   endproperty
   a_od_drive: assert property (p_od_drive) else $error("open drain drives high");
   property p_pp_drive;
      !od_ff && !$past(od_ff) |-> supply_valid_oe_out;
   endproperty
   a_pp_drive: assert property (p_pp_drive) else $error("push-pull pin released");
   property p_status_pol;
      s_status_read ##1 $stable(supply_valid_out) |-> rdata_out[5] == (supply_valid_out ~^ pol_ff);
   endproperty
   a_status_pol: assert property (p_status_pol) else $error("status and pin disagree");
   property p_limit_irq;
      lim_cnt_ff == 11'h3F2 && !mask_ff[0] |-> !irq_n_out;
   endproperty
   a_limit_irq: assert property (p_limit_irq) else $error("no irq after limit stay");
   property p_warn_irq;
      warn_cnt_ff == 11'h3F2 && !mask_ff[4] |-> !irq_n_out;
   endproperty
   a_warn_irq: assert property (p_warn_irq) else $error("no irq after warning");
endmodule // pgm_monitor_monitor
bind pgm_monitor pgm_monitor_monitor pgm_monitor_monitor_inst (.clock_in(clock_in), .rstn_in(rstn_in),
   .sense_in(sense_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .supply_valid_out(supply_valid_out), .supply_valid_oe_out(supply_valid_oe_out),
   .irq_n_out(irq_n_out));
`default_nettype wire

// file: bench/pgm_monitor_bench.sv
// self-checking bench of the supply valid and warning monitor
`timescale 1ns/1ns
`default_nettype none
module pgm_monitor_bench import pgm_pkg::*; ;
   logic clock_in = 1'b0;
   logic rstn_in = 1'b0;
   logic otp_done_in = 1'b0;
   logic otp_mode_in = 1'b1;
   logic [3:0] change_req_in = 4'h0;
   pgm_sense_type sense_in = 23'h7FF800;
   logic [7:0] addr_in = 8'h00;
   logic [15:0] wdata_in = 16'h0000;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [15:0] rdata_out;
   logic supply_valid_out;
   logic supply_valid_oe_out;
   logic irq_n_out;
   logic pin_seen;
   logic irq_seen;
   int err_count = 0;
   int total_checks = 0;
   always #10 clock_in = ~clock_in;
   pgm_monitor #(.GATE_CYC(20)) pgm_monitor_inst (.clock_in(clock_in), .rstn_in(rstn_in),
      .otp_done_in(otp_done_in), .otp_mode_in(otp_mode_in), .change_req_in(change_req_in),
      .sense_in(sense_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .supply_valid_out(supply_valid_out),
      .supply_valid_oe_out(supply_valid_oe_out), .irq_n_out(irq_n_out));
   pgm_host_model pgm_host_model_inst (.level_in(supply_valid_out), .oe_in(supply_valid_oe_out),
      .irq_n_in(irq_n_out), .pin_out(pin_seen), .irq_n_out(irq_seen));
   // ==========================================
   // access tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clock_in);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clock_in);
      wr_in <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clock_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clock_in);
      rd_in <= 1'b0;
      #1 chk(rdata_out, e);
   endtask
   // sense inputs cross two sync flops, state and pin: six cycles is settled
   task automatic vs(input logic [15:0] e);
      wt(6);
      rd(8'h05, e);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      wt(100000);
      err_count++;
      tally_and_finish;
   end
   // ==========================================
   // scenarios
   initial begin
      wt(16);
      rstn_in <= 1'b1;
      wt(4);
      otp_done_in <= 1'b1;
      wt(8);
      rd(8'h00, 16'h000F);
      rd(8'h01, 16'h0002);
      rd(8'h04, 16'h0000);
      wr(8'h0F, 16'hFFFF);
      rd(8'h0F, 16'h0000);
      vs(16'h0020);
      chk(16'(pin_seen), 16'h0000);
      sense_in.under_ok <= 4'hB;
      vs(16'h0000);
      chk(16'(pin_seen), 16'h0001);
      rd(8'h02, 16'h0004);
      sense_in.under_ok <= 4'hF;
      vs(16'h0020);
      rd(8'h02, 16'h0004);
      wr(8'h02, 16'h0004);
      rd(8'h02, 16'h0000);
      sense_in.over_ok <= 4'h7;
      vs(16'h0020);
      wr(8'h00, 16'h008F);
      vs(16'h0000);
      sense_in.over_ok <= 4'hF;
      wr(8'h02, 16'h000F);
      vs(16'h0020);
      sense_in.under_ok <= 4'hD;
      sense_in.rail_on <= 4'hD;
      vs(16'h0020);
      wr(8'h00, 16'h000D);
      sense_in.rail_on <= 4'hF;
      vs(16'h0020);
      wr(8'h01, 16'h000A);
      wr(8'h00, 16'h000F);
      vs(16'h0020);
      sense_in.under_ok <= 4'hF;
      wr(8'h01, 16'h0006);
      wr(8'h02, 16'h000F);
      sense_in.under_ok <= 4'hE;
      wt(6);
      sense_in.under_ok <= 4'hF;
      vs(16'h0000);
      wr(8'h02, 16'h0001);
      vs(16'h0020);
      wr(8'h01, 16'h0003);
      sense_in.thermal_warn <= 1'b1;
      wt(1010);
      vs(16'h0010);
      rd(8'h03, 16'h0010);
      chk(16'(irq_seen), 16'h0000);
      wr(8'h03, 16'h0010);
      rd(8'h03, 16'h0010);
      wr(8'h04, 16'h0010);
      chk(16'(irq_seen), 16'h0001);
      sense_in.thermal_warn <= 1'b0;
      wt(1010);
      wr(8'h03, 16'h0010);
      rd(8'h03, 16'h0000);
      wr(8'h04, 16'h0000);
      wr(8'h01, 16'h0002);
      sense_in.in_limit <= 4'h1;
      wt(990);
      sense_in.in_limit <= 4'h0;
      rd(8'h03, 16'h0000);
      sense_in.in_limit <= 4'hF;
      wt(1010);
      rd(8'h03, 16'h000F);
      vs(16'h002F);
      chk(16'(irq_seen), 16'h0000);
      wr(8'h04, 16'h007F);
      chk(16'(irq_seen), 16'h0001);
      wr(8'h04, 16'h0000);
      wr(8'h06, 16'h0001);
      rd(8'h06, 16'h0001);
      sense_in.in_limit <= 4'h0;
      vs(16'h0020);
      wr(8'h03, 16'h000F);
      rd(8'h03, 16'h0000);
      chk(16'(irq_seen), 16'h0001);
      for (int i = 0; i < 2; i++) begin
         if (i == 0) sense_in.overvoltage <= 1'b1;
         else sense_in.thermal_sd <= 1'b1;
         vs(16'h0000);
         sense_in.overvoltage <= 1'b0;
         sense_in.thermal_sd <= 1'b0;
         vs(16'h0000);
         wr(8'h03, 16'h0020 << i);
         vs(16'h0020);
      end
      sense_in.ramping <= 4'h2;
      vs(16'h0000);
      sense_in.ramping <= 4'h0;
      wr(8'h02, 16'h000F);
      vs(16'h0020);
      wr(8'h00, 16'h010F);
      wt(3);
      chk(16'(pin_seen), 16'h0001);
      rd(8'h05, 16'h0020);
      wr(8'h00, 16'h030F);
      wt(3);
      chk(16'(supply_valid_oe_out), 16'h0000);
      chk(16'(pin_seen), 16'h0001);
      sense_in.under_ok <= 4'hE;
      wt(6);
      chk(16'(supply_valid_oe_out), 16'h0001);
      chk(16'(pin_seen), 16'h0000);
      sense_in.under_ok <= 4'hF;
      wr(8'h00, 16'h000F);
      wr(8'h02, 16'h000F);
      wr(8'h01, 16'h0000);
      change_req_in <= 4'h1;
      wt(1);
      change_req_in <= 4'h0;
      sense_in.under_ok <= 4'hE;
      vs(16'h0020);
      wt(30);
      vs(16'h0000);
      sense_in.under_ok <= 4'hF;
      vs(16'h0000);
      wr(8'h02, 16'h0001);
      vs(16'h0020);
      rstn_in <= 1'b0;
      otp_done_in <= 1'b0;
      otp_mode_in <= 1'b0;
      wt(4);
      rstn_in <= 1'b1;
      wt(4);
      otp_done_in <= 1'b1;
      vs(16'h0020);
      rd(8'h01, 16'h0000);
      tally_and_finish;
   end
endmodule // pgm_monitor_bench
`default_nettype wire
